// [rtl/ddc_nco_preset_sync_control.sv]
// apb register bank steering oscillator presets, channel binding and phase sync
// Summary of operation
// - register field picks preset for converter b
// - register field picks preset for converter a
// - bit one routes channel b source
// - bit zero routes channel a source
// - digital channel follows bound source powerdown
// - one shared divisor for all presets
// - divisor removes residual frequency error
// - alignment edge initialises phase when enabled
// - arm zero then one, next sysref syncs
// - later sysref edges ignored until rearmed
// - mode zero uses registers, one uses pins, two uses pin a for both, three forces preset zero
// - phase word left aligned into accumulator
module ddc_nco_preset_sync_control #(
  parameter int freq_width = ddc_nco_pkg::freq_w,
  parameter int phase_width = ddc_nco_pkg::phase_w
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ddc_nco_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] preset_pins_a,
  input wire logic [1:0] preset_pins_b,
  input wire logic [ddc_nco_pkg::presets*freq_width-1:0] frequency_word_a,
  input wire logic [ddc_nco_pkg::presets*freq_width-1:0] frequency_word_b,
  input wire logic [ddc_nco_pkg::presets*phase_width-1:0] phase_word_a,
  input wire logic [ddc_nco_pkg::presets*phase_width-1:0] phase_word_b,
  input wire logic sysref,
  input wire logic ila_lmfc_edge,
  output ddc_nco_pkg::nco_setting_t nco_a,
  output ddc_nco_pkg::nco_setting_t nco_b,
  output ddc_nco_pkg::channel_route_t route,
  output logic [1:0] active_preset_a,
  output logic [1:0] active_preset_b,
  output logic phase_init,
  output logic serial_link_enable,
  output logic cal_enable
);
  import ddc_nco_pkg::*;

  logic [7:0] preset_source_mode_q;
  logic [7:0] oscillator_preset_select_q;
  logic [7:0] channel_binding_select_q;
  logic [15:0] rational_oscillator_divisor_q;
  logic [7:0] oscillator_phase_sync_control_q;
  logic [7:0] link_ctrl_q;
  logic sysref_q;
  arm_state_t arm_q;
  arm_state_t arm_d;
  logic phase_init_q;
  logic sync_event_seen_q;
  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic [11:0] word_idx;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic sysref_rise;
  logic arm_write;
  logic refused;
  logic [31:0] status_word;

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction : merge8

  function automatic logic [31:0] left_align(input logic [15:0] p);
    left_align = {p, 16'h0000};
  endfunction : left_align

  function automatic logic [freq_width-1:0] pick_freq(input logic [presets*freq_width-1:0] bank,
    input logic [1:0] sel);
    pick_freq = bank[sel*freq_width +: freq_width];
  endfunction : pick_freq

  function automatic logic [phase_width-1:0] pick_phase(input logic [presets*phase_width-1:0] bank,
    input logic [1:0] sel);
    pick_phase = bank[sel*phase_width +: phase_width];
  endfunction : pick_phase

  // powerdown of the converter channel a digital channel is bound to
  function automatic logic bound_pd(input logic src_is_b, input logic [7:0] ctrl);
    bound_pd = src_is_b ? ctrl[pd_b_pos] : ctrl[pd_a_pos];
  endfunction : bound_pd

  assign word_idx = paddr[13:2];
  assign hit = (word_idx == idx_preset_mode) || (word_idx == idx_preset_select) || (word_idx == idx_binding)
    || (word_idx == idx_divisor) || (word_idx == idx_sync) || (word_idx == idx_link_ctrl)
    || (word_idx == idx_status);
  assign pready = 1'b1;
  assign refused = !hit || (paddr[1:0] != 2'b00);
  assign pslverr = psel && penable && refused;
  assign wr_en = psel && penable && pwrite && !pslverr;
  // read data captured in setup so it stands at the access edge
  assign rd_en = psel && !penable && !pwrite;
  assign arm_write = wr_en && (word_idx == idx_sync) && pstrb[0];
  // sticky seen, powerdowns, armed flag, presets, arm state
  assign status_word = {20'h00000, sync_event_seen_q, route.pd_dig_b, route.pd_dig_a, arm_q == arm_armed,
    active_preset_b, active_preset_a, 2'b00, arm_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_source_mode_q <= rst_preset_mode;
    end else if (wr_en && word_idx == idx_preset_mode) begin
      preset_source_mode_q <= merge8(preset_source_mode_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_preset_select_q <= rst_preset_select;
    end else if (wr_en && word_idx == idx_preset_select) begin
      oscillator_preset_select_q <= merge8(oscillator_preset_select_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_binding_select_q <= rst_binding;
    end else if (wr_en && word_idx == idx_binding) begin
      channel_binding_select_q <= merge8(channel_binding_select_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rational_oscillator_divisor_q <= rst_divisor;
    end else if (wr_en && word_idx == idx_divisor) begin
      if (pstrb[0]) begin
        rational_oscillator_divisor_q[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        rational_oscillator_divisor_q[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_phase_sync_control_q <= rst_sync;
    end else if (arm_write) begin
      oscillator_phase_sync_control_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_ctrl_q <= rst_link_ctrl;
    end else if (wr_en && word_idx == idx_link_ctrl) begin
      link_ctrl_q <= merge8(link_ctrl_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en && refused) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      unique case (word_idx)
        idx_preset_mode: prdata <= {24'h000000, preset_source_mode_q};
        idx_preset_select: prdata <= {24'h000000, oscillator_preset_select_q};
        idx_binding: prdata <= {24'h000000, channel_binding_select_q};
        idx_divisor: prdata <= {16'h0000, rational_oscillator_divisor_q};
        idx_sync: prdata <= {24'h000000, oscillator_phase_sync_control_q};
        idx_link_ctrl: prdata <= {24'h000000, link_ctrl_q};
        idx_status: prdata <= status_word;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // register fields, pins or preset zero by mode
  always_comb begin
    sel_a = oscillator_preset_select_q[choice_a_lsb +: 2];
    sel_b = oscillator_preset_select_q[choice_b_lsb +: 2];
    unique case (preset_source_mode_q[1:0])
      2'b00: begin
        sel_a = oscillator_preset_select_q[choice_a_lsb +: 2];
        sel_b = oscillator_preset_select_q[choice_b_lsb +: 2];
      end
      2'b01: begin
        sel_a = preset_pins_a;
        sel_b = preset_pins_b;
      end
      2'b10: begin
        sel_a = preset_pins_a;
        sel_b = preset_pins_a;
      end
      default: begin
        sel_a = 2'b00;
        sel_b = 2'b00;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_preset_a <= 2'b00;
      active_preset_b <= 2'b00;
      nco_a <= '0;
      nco_b <= '0;
    end else begin
      active_preset_a <= sel_a;
      active_preset_b <= sel_b;
      nco_a.freq <= pick_freq(frequency_word_a, sel_a);
      nco_b.freq <= pick_freq(frequency_word_b, sel_b);
      nco_a.phase <= left_align(pick_phase(phase_word_a, sel_a));
      nco_b.phase <= left_align(pick_phase(phase_word_b, sel_b));
      nco_a.divisor <= rational_oscillator_divisor_q;
      nco_b.divisor <= rational_oscillator_divisor_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route <= '0;
    end else begin
      route.src_b_for_a <= channel_binding_select_q[bind_a_pos];
      route.src_b_for_b <= channel_binding_select_q[bind_b_pos];
      route.pd_dig_a <= bound_pd(channel_binding_select_q[bind_a_pos], link_ctrl_q);
      route.pd_dig_b <= bound_pd(channel_binding_select_q[bind_b_pos], link_ctrl_q);
    end
  end

  assign serial_link_enable = link_ctrl_q[link_en_pos];
  assign cal_enable = link_ctrl_q[cal_en_pos];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref;
    end
  end
  assign sysref_rise = sysref && !sysref_q;

  always_comb begin
    arm_d = arm_q;
    if (arm_write && !pwdata[sync_arm_pos]) begin
      arm_d = arm_primed;
    end else if (arm_write && pwdata[sync_arm_pos]) begin
      arm_d = (arm_q == arm_primed) ? arm_armed : arm_q;
    end else if (arm_q == arm_armed && sysref_rise) begin
      arm_d = arm_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= arm_idle;
    end else begin
      arm_q <= arm_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_init_q <= 1'b0;
    end else begin
      phase_init_q <= (oscillator_phase_sync_control_q[sync_ila_pos] && ila_lmfc_edge)
        || (arm_q == arm_armed && sysref_rise);
    end
  end
  assign phase_init = phase_init_q;

  // sticky seen flag, write to status clears, new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_event_seen_q <= 1'b0;
    end else if (phase_init_q) begin
      sync_event_seen_q <= 1'b1;
    end else if (wr_en && word_idx == idx_status) begin
      sync_event_seen_q <= 1'b0;
    end
  end
endmodule : ddc_nco_preset_sync_control

// [rtl/ddc_nco_pkg.sv]
// constants and carrier types for the oscillator preset and sync control block
package ddc_nco_pkg;
  // register word indices; byte address is four times the index
  localparam logic [11:0] idx_preset_mode = 12'h214;
  localparam logic [11:0] idx_preset_select = 12'h215;
  localparam logic [11:0] idx_binding = 12'h216;
  localparam logic [11:0] idx_divisor = 12'h217;
  localparam logic [11:0] idx_sync = 12'h219;
  localparam logic [11:0] idx_link_ctrl = 12'h220;
  localparam logic [11:0] idx_status = 12'h221;
  localparam int addr_w = 14;

  // field positions
  localparam int bind_a_pos = 0;
  localparam int bind_b_pos = 1;
  localparam int sync_arm_pos = 0;
  localparam int sync_ila_pos = 1;
  localparam int choice_a_lsb = 0;
  localparam int choice_b_lsb = 2;
  localparam int link_en_pos = 0;
  localparam int cal_en_pos = 1;
  localparam int pd_a_pos = 2;
  localparam int pd_b_pos = 3;

  // reset values
  localparam logic [7:0] rst_binding = 8'h02;
  localparam logic [15:0] rst_divisor = 16'h0000;
  localparam logic [7:0] rst_sync = 8'h02;
  localparam logic [7:0] rst_preset_select = 8'h00;
  localparam logic [7:0] rst_preset_mode = 8'h00;
  localparam logic [7:0] rst_link_ctrl = 8'h00;

  localparam int presets = 4;
  localparam int freq_w = 32;
  localparam int phase_w = 16;

  typedef enum logic [1:0] {
    arm_idle = 2'b00,
    arm_primed = 2'b01,
    arm_armed = 2'b10,
    arm_done = 2'b11
  } arm_state_t;

  typedef struct packed {
    logic [freq_w-1:0] freq;
    logic [freq_w-1:0] phase;
    logic [15:0] divisor;
  } nco_setting_t;

  typedef struct packed {
    logic pd_dig_a;
    logic pd_dig_b;
    logic src_b_for_a;
    logic src_b_for_b;
  } channel_route_t;
endpackage : ddc_nco_pkg

// [testbench/ddc_nco_properties.sv]
// port assertions for the oscillator control block
module ddc_nco_checker #(
  parameter int freq_width = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [4*freq_width-1:0] frequency_word_a,
  input wire logic sysref,
  input wire logic ila_lmfc_edge,
  input wire ddc_nco_pkg::nco_setting_t nco_a,
  input wire ddc_nco_pkg::nco_setting_t nco_b,
  input wire ddc_nco_pkg::channel_route_t route,
  input wire logic [1:0] active_preset_a,
  input wire logic [1:0] active_preset_b,
  input wire logic phase_init
);
  import ddc_nco_pkg::*;
  logic wr;
  logic sr_q;
  logic ila_q;
  logic [1:0] mode_q;
  logic [3:0] cause_q;
  logic [31:0] fa_sel;
  assign wr = psel && penable && pwrite && pready;
  assign fa_sel = frequency_word_a[active_preset_a*32+:32];
  // last written mode and alignment enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      ila_q <= 1'b1;
    end else if (wr && paddr == {idx_preset_mode, 2'b00}) begin
      mode_q <= pwdata[1:0];
    end else if (wr && paddr == {idx_sync, 2'b00}) begin
      ila_q <= pwdata[1];
    end
  end
  // recent alignment or sysref rise events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= 1'b0;
      cause_q <= 4'h0;
    end else begin
      sr_q <= sysref;
      cause_q <= {cause_q[2:0], ila_lmfc_edge | (sysref & ~sr_q)};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_select_b:
    assert property (wr && paddr == {idx_preset_select, 2'b00} && mode_q == 2'h0
      |-> ##2 active_preset_b == $past(pwdata[3:2], 2)) else $error("preset b select");
  a_select_a:
    assert property (wr && paddr == {idx_preset_select, 2'b00} && mode_q == 2'h0
      |-> ##2 active_preset_a == $past(pwdata[1:0], 2)) else $error("preset a select");
  a_freq_follows:
    assert property ($past(presetn) && $stable(active_preset_a) && $stable(frequency_word_a)
      |-> nco_a.freq == fa_sel) else $error("freq a mismatch");
  a_phase_left:
    assert property (nco_a.phase[15:0] == 16'h0 && nco_b.phase[15:0] == 16'h0) else $error("phase low bits");
  a_divisor_shared:
    assert property (wr && paddr == {idx_divisor, 2'b00}
      |-> ##2 nco_a.divisor == $past(pwdata[15:0], 2) && nco_b.divisor == nco_a.divisor) else $error("divisor");
  a_bind_route:
    assert property (wr && paddr == {idx_binding, 2'b00} |-> ##2 route.src_b_for_a == $past(pwdata[0], 2)
      && route.src_b_for_b == $past(pwdata[1], 2)) else $error("binding route");
  a_ila_init:
    assert property (ila_lmfc_edge && ila_q |-> ##[1:3] phase_init) else $error("no init on alignment");
  a_init_cause:
    assert property (phase_init |-> cause_q != 4'h0) else $error("init without cause");
endmodule : ddc_nco_checker

bind ddc_nco_preset_sync_control ddc_nco_checker #(.freq_width(freq_width)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .frequency_word_a, .sysref,
  .ila_lmfc_edge, .nco_a, .nco_b, .route, .active_preset_a, .active_preset_b, .phase_init
);

// [testbench/sysref_source.sv]
// external sysref pulse source
module sysref_source (
  input wire logic pclk,
  input wire logic fire,
  input wire logic [3:0] lag,
  output logic sysref
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sysref = 1'b0;
  always @(posedge fire) begin
    repeat (lag) @(posedge pclk);
    sysref <= 1'b1;
    repeat (3) @(posedge pclk);
    sysref <= 1'b0;
  end
endmodule : sysref_source

// [testbench/ddc_nco_preset_sync_control_tb.sv]
// testbench for the oscillator preset and sync control block
module ddc_nco_preset_sync_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddc_nco_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] preset_pins_a = 2'h2;
  logic [1:0] preset_pins_b = 2'h1;
  logic [127:0] frequency_word_a = {32'h4000_0003, 32'h3000_0002, 32'h2000_0001, 32'h1000_0000};
  logic [127:0] frequency_word_b = {32'hc000_0003, 32'hb000_0002, 32'ha000_0001, 32'h9000_0000};
  logic [63:0] phase_word_a = 64'h4004_3003_2002_1001;
  logic [63:0] phase_word_b = 64'hd00d_c00c_b00b_a00a;
  logic go = 1'b0;
  logic [3:0] lag = 4'h1;
  logic sysref;
  logic ila_lmfc_edge = 1'b0;
  nco_setting_t nco_a;
  nco_setting_t nco_b;
  channel_route_t route;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic phase_init;
  logic [31:0] rd;
  logic err;
  logic link_en;
  logic cal_en;
  int fails = 0;
  int cmp_count = 0;
  int inits = 0;
  ddc_nco_preset_sync_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .preset_pins_a, .preset_pins_b, .frequency_word_a, .frequency_word_b,
    .phase_word_a, .phase_word_b, .sysref, .ila_lmfc_edge, .nco_a, .nco_b, .route,
    .active_preset_a(act_a), .active_preset_b(act_b), .phase_init, .serial_link_enable(link_en),
    .cal_enable(cal_en));
  sysref_source src (.pclk, .fire(go), .lag, .sysref);
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (phase_init === 1'b1) inits++;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : xfer
  task automatic fire(input logic [3:0] l);
    @(posedge pclk);
    lag <= l;
    go <= 1'b1;
    ila_lmfc_edge <= l == 4'h0;
    @(posedge pclk);
    go <= 1'b0;
    ila_lmfc_edge <= 1'b0;
    repeat (16) @(posedge pclk);
  endtask : fire
  task automatic t_reset;
    xfer(1'b0, idx_binding, 32'h0);
    chk("binding", 32'h02, rd);
    xfer(1'b0, idx_sync, 32'h0);
    chk("sync", 32'h02, rd);
    xfer(1'b1, 12'h21a, 32'hffff);
    chk("refused", 32'h1, {31'h0, err});
    xfer(1'b0, idx_divisor, 32'h0);
    chk("divisor", 32'h0, rd);
    chk("accepted", 32'h0, {31'h0, err});
    chk("route", 32'h1, {28'h0, route});
    $display("reset test done");
  endtask : t_reset
  task automatic t_preset;
    xfer(1'b1, idx_divisor, 32'hb5a3);
    for (int n = 0; n < 4; n++) begin
      xfer(1'b1, idx_preset_select, 32'(((3 - n) << 2) | n));
      chk("preset a", 32'(n), {30'h0, act_a});
      chk("preset b", 32'(3 - n), {30'h0, act_b});
      chk("freq a", frequency_word_a[n*32+:32], nco_a.freq);
      chk("phase a", {phase_word_a[n*16+:16], 16'h0}, nco_a.phase);
      chk("freq b", frequency_word_b[(3-n)*32+:32], nco_b.freq);
      chk("divisor", 32'hb5a3_b5a3, {nco_a.divisor, nco_b.divisor});
    end
    for (int m = 1; m < 4; m++) begin
      xfer(1'b1, idx_preset_mode, 32'(m));
      chk("pin a", m == 3 ? 32'h0 : 32'h2, {30'h0, act_a});
      chk("pin b", m == 1 ? 32'h1 : m == 2 ? 32'h2 : 32'h0, {30'h0, act_b});
    end
    xfer(1'b1, idx_preset_mode, 32'h0);
    chk("back a", 32'h3, {30'h0, act_a});
    $display("preset test done");
  endtask : t_preset
  task automatic t_bind;
    logic [1:0] b;
    logic q;
    xfer(1'b1, idx_link_ctrl, 32'h3);
    chk("link enables", 32'h3, {30'h0, cal_en, link_en});
    for (int i = 0; i < 8; i++) begin
      b = 2'(i);
      q = i > 3;
      // link and calibration bits stay clear
      xfer(1'b1, idx_link_ctrl, q ? 32'h8 : 32'h4);
      xfer(1'b1, idx_binding, 32'(b));
      chk("route", {28'h0, b[0] == q, b[1] == q, b[0], b[1]}, {28'h0, route});
    end
    xfer(1'b1, idx_binding, 32'h2);
    xfer(1'b1, idx_link_ctrl, 32'h0);
    chk("link enables", 32'h0, {30'h0, cal_en, link_en});
    $display("binding test done");
  endtask : t_bind
  task automatic t_sync;
    int c;
    c = inits;
    fire(4'h0);
    chk("align init", 32'(c + 1), 32'(inits));
    // alignment off, then arm low and high
    xfer(1'b1, idx_sync, 32'h0);
    xfer(1'b1, idx_sync, 32'h1);
    fire(4'h0);
    fire(4'h6);
    chk("sysref init", 32'(c + 2), 32'(inits));
    xfer(1'b0, idx_status, 32'h0);
    chk("status", 32'h833, rd);
    xfer(1'b1, idx_sync, 32'h1);
    fire(4'h1);
    chk("ignored", 32'(c + 2), 32'(inits));
    xfer(1'b1, idx_sync, 32'h0);
    xfer(1'b1, idx_sync, 32'h1);
    fire(4'h1);
    chk("rearmed", 32'(c + 3), 32'(inits));
    $display("sync test done");
  endtask : t_sync
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_preset();
    t_bind();
    t_sync();
    wrap_up();
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule : ddc_nco_preset_sync_control_tb
